// ---- kbsic_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module kbsic_ctrl
  import kbsic_pkg::*;
#(
  parameter int unsigned TIMEOUT_CY = LINK_TIMEOUT_CY,
  parameter int unsigned INHIBIT_C  = INHIBIT_CY
)(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // host side
  input  wire logic       wr_in,          // pulse: byte to send
  input  wire logic [7:0] wr_data_in,
  input  wire logic       rd_in,          // pulse: output buffer read
  input  wire logic       irq_en_in,
  input  wire logic       xlat_en_in,
  output logic [7:0]      rd_data_out,
  output logic            obf_out,        // output buffer full
  output logic            ibf_out,        // send pending, held until the response byte or a failed send
  output logic            par_err_out,
  output logic            tmo_err_out,
  output logic            irq_out,
  // keyboard link, open drain
  input  wire logic       kclk_in,
  input  wire logic       kdat_in,
  output logic            kclk_oe_b_out,  // low: pull clock low
  output logic            kdat_oe_b_out   // low: pull data low
);
  typedef struct packed {
    kbsic_state_t         st;
    logic [2:0]           ck_sy;   // clock sync, then edge history
    logic [1:0]           dt_sy;   // data sync
    logic [BIT_CNT_W-1:0] bits;
    logic [9:0]           sh;      // receive or send shift
    logic [TIMER_W-1:0]   tmr;
    logic [7:0]           ob;      // output buffer
    logic                 obf;
    logic                 ibf;
    logic                 perr;
    logic                 terr;
    logic                 code_vld;
    logic [7:0]           code;
    logic                 ack_vld; // send acknowledged, response awaited
    logic                 kclk_lo;
    logic                 kdat_lo;
  } kbsic_st_t;

  kbsic_st_t s_q;
  kbsic_st_t s_d;

  logic       xl_vld;              // translated byte strobe
  logic [7:0] xl_byte;             // translated byte
  logic       fall;                // synced falling clock edge
  logic       dbit;                // synced data

  // scan code translator
  kbsic_xlat u_xlat (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .code_vld_in  (s_q.code_vld),
    .code_in      (s_q.code),
    .xlat_en_in   (xlat_en_in),
    .byte_vld_out (xl_vld),
    .byte_out     (xl_byte)
  );

  // edge detect reads only the second and third stages
  assign fall = s_q.ck_sy[2] & ~s_q.ck_sy[1];
  assign dbit = s_q.dt_sy[1];

  // next state
  always_comb begin
    s_d          = s_q;
    s_d.ck_sy    = {s_q.ck_sy[1:0], kclk_in};
    s_d.dt_sy    = {s_q.dt_sy[0], kdat_in};
    s_d.code_vld = 1'b0;
    // host read empties the buffer; a fill in the same cycle wins below
    if (rd_in) begin
      s_d.obf  = 1'b0;
      s_d.perr = 1'b0;
      s_d.terr = 1'b0;
    end
    // host write accepted only when no send is outstanding
    if (wr_in && !s_q.ibf) begin
      s_d.ibf = 1'b1;
      s_d.sh  = {~^wr_data_in, wr_data_in, 1'b0};
    end
    unique case (s_q.st)
      KBSIC_IDLE: begin
        s_d.tmr = '0;
        // an acknowledged send only waits for its response; claiming again would resend
        if (s_q.ibf && !s_q.ack_vld && s_q.bits == '0) begin
          // pull clock low to claim the link
          s_d.st      = KBSIC_INHIBIT;
          s_d.kclk_lo = 1'b1;
        end else if (fall && !dbit) begin
          s_d.st   = KBSIC_RX;                          // start bit
          s_d.bits = BIT_CNT_W'(1);
        end
      end
      KBSIC_RX: begin
        s_d.tmr = s_q.tmr + 1'b1;
        if (fall) begin
          s_d.bits = s_q.bits + 1'b1;
          if (s_q.bits == BIT_CNT_W'(FRAME_BITS - 1)) begin
            // stop bit: data byte in sh[7:0], parity in sh[8]
            s_d.st   = KBSIC_IDLE;
            s_d.bits = '0;
            if (!dbit || (^s_q.sh[8:0]) != 1'b1) begin
              s_d.perr = 1'b1;
              s_d.ob   = 8'hFF;
              s_d.obf  = 1'b1;
            end else begin
              s_d.code_vld = 1'b1;
              s_d.code     = s_q.sh[7:0];
            end
          end else begin
            s_d.sh = {1'b0, dbit, s_q.sh[8:1]};         // lsb first
          end
        end else if (s_q.tmr == TIMER_W'(TIMEOUT_CY)) begin
          s_d.st   = KBSIC_IDLE;
          s_d.bits = '0;
          s_d.terr = 1'b1;
        end
      end
      KBSIC_INHIBIT: begin
        s_d.tmr = s_q.tmr + 1'b1;
        if (s_q.tmr == TIMER_W'(INHIBIT_C)) begin
          // data low is the start bit; clock released in the same cycle
          s_d.kdat_lo = 1'b1;
          s_d.kclk_lo = 1'b0;
          s_d.st      = KBSIC_TX;
          s_d.tmr     = '0;
          s_d.sh      = s_q.sh >> 1;
          s_d.bits    = '0;
        end
      end
      KBSIC_TX: begin
        s_d.tmr = s_q.tmr + 1'b1;
        if (fall) begin
          s_d.bits = s_q.bits + 1'b1;
          if (s_q.bits == BIT_CNT_W'(9)) begin
            s_d.kdat_lo = 1'b0;                         // stop bit released
            s_d.st      = KBSIC_WAITACK;
          end else begin
            s_d.kdat_lo = ~s_q.sh[0];
            s_d.sh      = s_q.sh >> 1;
          end
        end else if (s_q.tmr == TIMER_W'(TIMEOUT_CY)) begin
          s_d.st      = KBSIC_IDLE;
          s_d.kdat_lo = 1'b0;
          s_d.ibf     = 1'b0;
          s_d.bits    = '0;
          s_d.terr    = 1'b1;
        end
      end
      KBSIC_WAITACK: begin
        s_d.tmr = s_q.tmr + 1'b1;
        if (fall) begin
          // line acknowledge: keyboard holds data low on the last edge
          s_d.bits = '0;
          s_d.st   = KBSIC_IDLE;
          if (dbit) begin
            // no acknowledge: give up the send
            s_d.terr = 1'b1;
            s_d.ibf  = 1'b0;
          end else begin
            // acknowledged: hold the send open until the response
            s_d.ack_vld = 1'b1;
          end
        end else if (s_q.tmr == TIMER_W'(TIMEOUT_CY)) begin
          s_d.st   = KBSIC_IDLE;
          s_d.ibf  = 1'b0;
          s_d.bits = '0;
          s_d.terr = 1'b1;
        end
      end
      default: begin
        s_d.st = KBSIC_IDLE;
      end
    endcase
    // response byte after a send closes the pending send
    if (s_q.code_vld && s_q.ibf && s_q.ack_vld) begin
      s_d.ibf     = 1'b0;
      s_d.ack_vld = 1'b0;
    end
    // translated byte into the output buffer; set beats a same-cycle read
    if (xl_vld) begin
      s_d.ob  = xl_byte;
      s_d.obf = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '{st: KBSIC_IDLE, ck_sy: 3'h7, dt_sy: 2'h3, bits: '0, sh: '0, tmr: '0,
               ob: DATA_RST, obf: 1'b0, ibf: 1'b0, perr: 1'b0, terr: 1'b0,
               code_vld: 1'b0, code: DATA_RST, ack_vld: 1'b0,
               kclk_lo: 1'b0, kdat_lo: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign rd_data_out   = s_q.ob;
  assign obf_out       = s_q.obf;
  assign ibf_out       = s_q.ibf;
  assign par_err_out   = s_q.perr;
  assign tmo_err_out   = s_q.terr;
  assign irq_out       = s_q.obf & irq_en_in;
  assign kclk_oe_b_out = ~s_q.kclk_lo;
  assign kdat_oe_b_out = ~s_q.kdat_lo;
endmodule : kbsic_ctrl
`default_nettype wire

// ---- kbsic_ctrl_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
// port checks of the keyboard link controller
module kbsic_ctrl_assertions
  import kbsic_pkg::*;
#(
  parameter int unsigned TIMEOUT_CY = LINK_TIMEOUT_CY,
  parameter int unsigned INHIBIT_C  = INHIBIT_CY
)(
  // clock, reset and host side
  input wire logic       clk_in, rst_b_in, wr_in, rd_in, irq_en_in,
  input wire logic [7:0] rd_data_out,
  input wire logic       obf_out, ibf_out, par_err_out, tmo_err_out, irq_out,
  // link drivers
  input wire logic       kclk_oe_b_out, kdat_oe_b_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // an accepted send request
  sequence s_req; wr_in && !ibf_out; endsequence
  // clock held low before a send
  sequence s_inhibit; !kclk_oe_b_out [*8]; endsequence

  a_irq_follows_obf: assert property (irq_out == (obf_out & irq_en_in))
    else $error("irq differs from buffer full and enable");
  a_send_taken: assert property (s_req |=> ibf_out ##1 !kclk_oe_b_out)
    else $error("send request not started");
  a_inhibit_hold: assert property ($fell(kclk_oe_b_out) |-> s_inhibit)
    else $error("clock inhibit too short");
  a_obf_stands: assert property (obf_out && !rd_in |=> obf_out)
    else $error("buffer full dropped without read");
  a_perr_byte: assert property ($rose(par_err_out) |-> obf_out && rd_data_out == 8'hFF)
    else $error("parity error without error byte");
  a_data_only_send: assert property (!kdat_oe_b_out |-> ibf_out)
    else $error("data driven outside a send");
  a_send_ends: assert property ($fell(ibf_out) |-> ##[0:4] (obf_out || tmo_err_out))
    else $error("send ended without answer");
  a_wr_ignored: assert property (ibf_out && wr_in |=> ibf_out)
    else $error("pending send dropped by new request");
  a_claim_once: assert property ($fell(kclk_oe_b_out) |-> !$past(ibf_out, 2))
    else $error("link claimed again for a pending send");
endmodule : kbsic_ctrl_assertions

bind kbsic_ctrl kbsic_ctrl_assertions #(.TIMEOUT_CY(TIMEOUT_CY), .INHIBIT_C(INHIBIT_C)) u_chk (
  .clk_in, .rst_b_in, .wr_in, .rd_in, .irq_en_in, .rd_data_out, .obf_out, .ibf_out,
  .par_err_out, .tmo_err_out, .irq_out, .kclk_oe_b_out, .kdat_oe_b_out);
`default_nettype wire

// ---- kbsic_kbd_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// keyboard on the open-drain link; low output pulls the line
module kbsic_kbd_model (
  // wired line levels
  input wire logic kclk_in, kdat_in,
  // pull drivers, high releases
  output logic     kclk_b_out, kdat_b_out
);
  // both lines released at start
  initial begin
    kclk_b_out = 1'b1;
    kdat_b_out = 1'b1;
  end
  // keyboard to host frame, 80 ns link clock, idle high between frames
  task automatic send(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    f = {1'b1, ~^b ^ bad, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      kdat_b_out = f[i];
      #20 kclk_b_out = 1'b0;
      #40 kclk_b_out = 1'b1;
      #20;
    end
    kdat_b_out = 1'b1;
  endtask : send
  // host to keyboard frame: sample after each rising edge, then acknowledge if asked
  task automatic recv(output logic [9:0] f, input logic ack);
    wait (kclk_in === 1'b0);
    wait (kclk_in === 1'b1 && kdat_in === 1'b0);
    for (int i = 0; i < 10; i++) begin
      #40 kclk_b_out = 1'b0;
      #40 kclk_b_out = 1'b1;
      f[i] = kdat_in;
    end
    kdat_b_out = ~ack;
    #40 kclk_b_out = 1'b0;
    #40 kclk_b_out = 1'b1;
    kdat_b_out = 1'b1;
  endtask : recv
endmodule : kbsic_kbd_model
`default_nettype wire

// ---- kbsic_pkg.sv ----
package kbsic_pkg;
  // link timing, in cycles of the 125 MHz clock
  localparam int unsigned CLK_MHZ         = 125;
  localparam int unsigned LINK_TIMEOUT_US = 2000;   // give up on a stalled frame
  localparam int unsigned LINK_TIMEOUT_CY = LINK_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned INHIBIT_US      = 100;    // clock held low before a send
  localparam int unsigned INHIBIT_CY      = INHIBIT_US * CLK_MHZ;
  // frame layout: start, 8 data, parity, stop
  localparam int unsigned FRAME_BITS      = 11;
  localparam int unsigned BIT_CNT_W       = 4;
  localparam int unsigned TIMER_W         = 20;
  // value after reset, and the break prefix code
  localparam logic [7:0]  DATA_RST        = 8'h00;
  localparam logic [7:0]  BREAK_CODE      = 8'hF0;

  // controller states, one-hot
  typedef enum logic [4:0] {
    KBSIC_IDLE    = 5'b00001,
    KBSIC_RX      = 5'b00010,
    KBSIC_INHIBIT = 5'b00100,
    KBSIC_TX      = 5'b01000,
    KBSIC_WAITACK = 5'b10000
  } kbsic_state_t;
endpackage : kbsic_pkg

// ---- kbsic_xlat.sv ----
`timescale 1ns/1ns
`default_nettype none
// scan code translation: set-2 style codes folded to set-1 style codes,
// break prefix merged into bit 7 of the following code
module kbsic_xlat
  import kbsic_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // raw code in
  input  wire logic       code_vld_in,
  input  wire logic [7:0] code_in,
  input  wire logic       xlat_en_in,
  // translated byte out
  output logic            byte_vld_out,
  output logic [7:0]      byte_out
);
  typedef struct packed {
    logic       brk;   // break prefix seen
    logic       vld;   // output strobe
    logic [7:0] dat;   // output byte
  } kbsic_xst_t;

  kbsic_xst_t s_q;
  kbsic_xst_t s_d;

  // small lookup for common codes; others pass with their low seven bits
  function automatic logic [7:0] map(input logic [7:0] c);
    unique case (c)
      8'h76:   map = 8'h01;
      8'h16:   map = 8'h02;
      8'h1E:   map = 8'h03;
      8'h26:   map = 8'h04;
      8'h15:   map = 8'h10;
      8'h1D:   map = 8'h11;
      8'h1C:   map = 8'h1E;
      8'h1B:   map = 8'h1F;
      8'h5A:   map = 8'h1C;
      8'h29:   map = 8'h39;
      8'h66:   map = 8'h0E;
      8'h0D:   map = 8'h0F;
      default: map = {1'b0, c[6:0]};
    endcase
  endfunction : map

  // next state
  always_comb begin
    s_d     = s_q;
    s_d.vld = 1'b0;
    if (code_vld_in) begin
      if (!xlat_en_in) begin
        // translation off: raw byte through
        s_d.vld = 1'b1;
        s_d.dat = code_in;
      end else if (code_in == BREAK_CODE) begin
        // hold prefix until the code that follows
        s_d.brk = 1'b1;
      end else begin
        s_d.vld = 1'b1;
        s_d.dat = map(code_in) | {s_q.brk, 7'h00};
        s_d.brk = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '{brk: 1'b0, vld: 1'b0, dat: DATA_RST};
    end else begin
      s_q <= s_d;
    end
  end

  assign byte_vld_out = s_q.vld;
  assign byte_out     = s_q.dat;
endmodule : kbsic_xlat
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // design inputs and outputs
  logic       clk_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, irq_en_in = 1'b0, xlat_en_in = 1'b0;
  logic [7:0] wr_data_in = 8'h00, rd_data_out, b;
  logic       obf_out, ibf_out, par_err_out, tmo_err_out, irq_out, kclk_oe_b_out, kdat_oe_b_out, kb_clk_b, kb_dat_b;
  // wired-and lines with pull-up
  wire logic  kclk_w = kclk_oe_b_out & kb_clk_b;
  wire logic  kdat_w = kdat_oe_b_out & kb_dat_b;
  int         error_cnt = 0, tests_run = 0, cyc = 0;
  logic [7:0] exp_q[$]; // expected buffer bytes
  logic [9:0] f;

  kbsic_ctrl #(.TIMEOUT_CY(2000), .INHIBIT_C(50)) i_dut (.clk_in, .rst_b_in, .wr_in, .wr_data_in, .rd_in,
    .irq_en_in, .xlat_en_in, .rd_data_out, .obf_out, .ibf_out, .par_err_out, .tmo_err_out, .irq_out,
    .kclk_in(kclk_w), .kdat_in(kdat_w), .kclk_oe_b_out, .kdat_oe_b_out);
  kbsic_kbd_model i_kbd (.kclk_in(kclk_w), .kdat_in(kdat_w), .kclk_b_out(kb_clk_b), .kdat_b_out(kb_dat_b));

  // 125 MHz clock
  always #4 clk_in = ~clk_in;
  // hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run;
    end
  end
  // one comparison
  task automatic chk(input logic [7:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t exp %h got %h", $time, exp, got);
    end
  endtask : chk
  // wait for buffer full, compare, then read
  task automatic wait_obf(input logic pe, input logic [7:0] m);
    for (int n = 0; n < 400; n++) begin
      @(posedge clk_in);
      #1;
      if (obf_out === 1'b1) break;
    end
    chk(8'h01, {7'h0, obf_out});
    chk(exp_q.pop_front() & m, rd_data_out & m);
    chk({7'h0, pe}, {7'h0, par_err_out});
    chk({7'h0, irq_en_in}, {7'h0, irq_out});
    chk(8'h00, {7'h0, tmo_err_out});
    @(posedge clk_in) rd_in <= 1'b1;
    @(posedge clk_in) rd_in <= 1'b0;
  endtask : wait_obf
  // keyboard sends one byte
  task automatic rx(input logic [7:0] v, input logic bad);
    exp_q.push_back(bad ? 8'hFF : v);
    i_kbd.send(v, bad);
    wait_obf(bad, 8'hFF);
  endtask : rx
  // host sends one byte, a second request while pending is ignored
  task automatic tx(input logic [7:0] v);
    @(posedge clk_in) begin wr_in <= 1'b1; wr_data_in <= v; end
    @(posedge clk_in) wr_in <= 1'b0;
    @(posedge clk_in) begin wr_in <= 1'b1; wr_data_in <= ~v; end
    @(posedge clk_in) wr_in <= 1'b0;
    i_kbd.recv(f, 1'b1);
    chk(v, f[7:0]);
    chk({7'h0, ~^v}, {7'h0, f[8]});
    chk(8'h01, {7'h0, f[9]});
    chk(8'h01, {7'h0, ibf_out});
    exp_q.push_back(8'hFA);
    i_kbd.send(8'hFA, 1'b0);
    wait_obf(1'b0, 8'hFF);
    chk(8'h00, {7'h0, ibf_out});
  endtask : tx
  // verdict and end of run
  task automatic complete_run;
    if (error_cnt == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    void'($urandom(16238));
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk_in) irq_en_in <= i[0];
      b = 8'($urandom);
      rx(b, i == 3);
      tx(8'($urandom));
    end
    // missing acknowledge ends the send with the timeout flag
    @(posedge clk_in) begin wr_in <= 1'b1; wr_data_in <= 8'($urandom); end
    @(posedge clk_in) wr_in <= 1'b0;
    i_kbd.recv(f, 1'b0);
    repeat (8) @(posedge clk_in);
    chk(8'h01, {7'h0, tmo_err_out});
    chk(8'h00, {7'h0, ibf_out});
    @(posedge clk_in) rd_in <= 1'b1;
    @(posedge clk_in) rd_in <= 1'b0;
    // break prefix is swallowed and marks the next code
    @(posedge clk_in) xlat_en_in <= 1'b1;
    i_kbd.send(8'hF0, 1'b0);
    repeat (20) @(posedge clk_in);
    chk(8'h00, {7'h0, obf_out});
    exp_q.push_back(8'h80);
    i_kbd.send(8'h1C, 1'b0);
    wait_obf(1'b0, 8'h80);
    complete_run;
  end
endmodule : testbench
`default_nettype wire
